// [logic/iess_top.sv]
// Interrupt enable, external sense and sleep control with APB registers
// Overview of operation
// - Timer1 overflow enabled with global flag requests vector 0x006.
// - Compare-A enabled with global flag requests vector 0x004.
// - Compare-B enabled with global flag requests vector 0x005.
// - Capture enabled with global flag requests vector 0x003.
// - Timer0 overflow enabled with global flag requests vector 0x007.
// - Timer mask bits 4, 2, 0 read as zero.
// - Sleep instruction sleeps only when sleep arm bit is one.
// - Sleep kind bit zero gives idle, one gives power-down.
// - External interrupt 1 requests only with global flag and its mask.
// - Ext1 sense: 00 low, 01 reserved, 10 falling, 11 rising.
// - Ext0 gated likewise and uses the same sense encoding.
// - Pins are sampled before edge detection; short pulses may be lost.
// - Low-level request persists while pin is low and enabled.
// - Ext flag clears on service or written one; stays clear in level mode.
// - Lowest pending vector is served first.
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/100ps
module iess_top
	import iess_pkg::*;
(
	// Clock and reset
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	// APB slave
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [7:0]           paddr,
	input  wire logic [31:0]          pwdata,
	input  wire logic [3:0]           pstrb,
	output logic [31:0]               prdata,
	output logic                      pready,
	output logic                      pslverr,
	// Core side
	input  wire logic                 global_irq_en,
	input  wire logic                 sleep_exec,
	input  wire logic                 irq_ack,
	input  wire logic [11:0]          irq_ack_vector,
	output iess_pkg::iess_req_t       irq_req,
	output iess_pkg::iess_slp_t       sleep_state,
	// Timer flags
	input  wire iess_pkg::iess_tflags_t timer_flags,
	// External pins
	input  wire logic                 ext_irq_pin_0,
	input  wire logic                 ext_irq_pin_1,
	// Interrupt line
	output logic                      irq
);
	import iess_pkg::*;

	logic [7:0]         tmask_r, tmask_nxt, ctrl_r, ctrl_nxt, gmask_r, gmask_nxt;
	logic [IESS_EV_N-1:0] stat_r, stat_nxt, ien_r, ien_nxt;
	iess_slp_t          slp_r, slp_nxt;
	logic [31:0]        rdata_r, rdata_nxt;
	logic               wr_acc, rd_acc, hit;
	logic               e0_flag, e1_flag, e0_lvl, e1_lvl, e0_clr, e1_clr, wake;
	logic [6:0]         req, grant;
	iess_req_t          win;

	function automatic logic is_reg(input logic [7:0] a);
		return a inside {IESS_TMASK_OFF, IESS_TFLAG_OFF, IESS_CTRL_OFF, IESS_GMASK_OFF,
			IESS_GFLAG_OFF, IESS_STAT_OFF, IESS_IEN_OFF, IESS_ICLR_OFF};
	endfunction

	function automatic logic ack_of(input logic [11:0] v);
		return irq_ack && (irq_ack_vector == v);
	endfunction

	assign hit    = is_reg(paddr);
	assign wr_acc = psel & penable & pwrite & hit & pstrb[0];
	assign rd_acc = psel & ~penable & ~pwrite;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~hit;

	// Register writes
	always_comb begin
		tmask_nxt = tmask_r;
		ctrl_nxt  = ctrl_r;
		gmask_nxt = gmask_r;
		ien_nxt   = ien_r;
		if (wr_acc) begin
			unique case (paddr)
				IESS_TMASK_OFF: tmask_nxt = pwdata[7:0] & IESS_TMASK_WMASK;
				IESS_CTRL_OFF:  ctrl_nxt  = pwdata[7:0];
				IESS_GMASK_OFF: gmask_nxt = pwdata[7:0] & IESS_GMASK_WMASK;
				IESS_IEN_OFF:   ien_nxt   = pwdata[IESS_EV_N-1:0];
				default: ;
			endcase
		end
	end

	// Ext flags cleared by written one or by service entry
	assign e0_clr = (wr_acc && paddr == IESS_GFLAG_OFF && pwdata[IESS_EXT0_BIT])
		|| ack_of(IESS_VEC_EXT0);
	assign e1_clr = (wr_acc && paddr == IESS_GFLAG_OFF && pwdata[IESS_EXT1_BIT])
		|| ack_of(IESS_VEC_EXT1);

	iess_sense u_ext0 (
		.pclk      (pclk),
		.presetn   (presetn),
		.pin       (ext_irq_pin_0),
		.sense     (iess_sense_t'(ctrl_r[IESS_EXT0_SNS_LO +: 2])),
		.clr       (e0_clr),
		.flag      (e0_flag),
		.level_req (e0_lvl)
	);

	iess_sense u_ext1 (
		.pclk      (pclk),
		.presetn   (presetn),
		.pin       (ext_irq_pin_1),
		.sense     (iess_sense_t'(ctrl_r[IESS_EXT1_SNS_LO +: 2])),
		.clr       (e1_clr),
		.flag      (e1_flag),
		.level_req (e1_lvl)
	);

	// Source flags held by the timer stay pending until enabled
	always_comb begin
		req    = 7'h00;
		req[0] = global_irq_en & gmask_r[IESS_EXT0_BIT] & (e0_flag | e0_lvl);
		req[1] = global_irq_en & gmask_r[IESS_EXT1_BIT] & (e1_flag | e1_lvl);
		req[2] = global_irq_en & tmask_r[IESS_CAP_BIT] & timer_flags.capture_flag;
		req[3] = global_irq_en & tmask_r[IESS_CMPA_BIT] & timer_flags.cmp_a_flag;
		req[4] = global_irq_en & tmask_r[IESS_CMPB_BIT] & timer_flags.cmp_b_flag;
		req[5] = global_irq_en & tmask_r[IESS_T1OVF_BIT] & timer_flags.t1_ovf_flag;
		req[6] = global_irq_en & tmask_r[IESS_T0OVF_BIT] & timer_flags.t0_ovf_flag;
	end

	iess_prio u_prio (
		.req   (req),
		.win   (win),
		.grant (grant)
	);

	// Pending flags raise the request as soon as their enables are set
	assign irq_req = win;

	// Sleep state; any enabled request wakes idle, only an external request wakes power-down
	assign wake = win.valid;
	always_comb begin
		slp_nxt = slp_r;
		unique case (slp_r)
			IESS_AWAKE: begin
				if (sleep_exec && ctrl_r[IESS_SLEEP_ARM_BIT]) begin
					slp_nxt = ctrl_r[IESS_SLEEP_SEL_BIT] ? IESS_PDOWN : IESS_IDLE;
				end
			end
			IESS_IDLE:  if (wake) slp_nxt = IESS_AWAKE;
			IESS_PDOWN: if (wake && grant[1:0] != 2'b00) slp_nxt = IESS_AWAKE;
			default:    slp_nxt = IESS_AWAKE;
		endcase
	end

	// Sticky event status; set wins over clear
	always_comb begin
		stat_nxt = stat_r;
		if (wr_acc && paddr == IESS_ICLR_OFF) begin
			stat_nxt = stat_r & ~pwdata[IESS_EV_N-1:0];
		end
		if (slp_r == IESS_AWAKE && slp_nxt != IESS_AWAKE) stat_nxt[IESS_EV_SLEEP] = 1'b1;
		if (slp_r != IESS_AWAKE && slp_nxt == IESS_AWAKE) stat_nxt[IESS_EV_WAKE] = 1'b1;
		if (irq_ack) stat_nxt[IESS_EV_ACK] = 1'b1;
	end

	// Read data registered in setup phase
	always_comb begin
		rdata_nxt = rdata_r;
		if (rd_acc) begin
			rdata_nxt = 32'h0000_0000;
			unique case (paddr)
				IESS_TMASK_OFF: rdata_nxt[7:0] = tmask_r & IESS_TMASK_WMASK;
				IESS_TFLAG_OFF: rdata_nxt[7:0] = {timer_flags.t1_ovf_flag,
					timer_flags.cmp_a_flag, timer_flags.cmp_b_flag, 1'b0,
					timer_flags.capture_flag, 1'b0, timer_flags.t0_ovf_flag, 1'b0};
				IESS_CTRL_OFF:  rdata_nxt[7:0] = ctrl_r;
				IESS_GMASK_OFF: rdata_nxt[7:0] = gmask_r;
				IESS_GFLAG_OFF: rdata_nxt[7:0] = {e1_flag, e0_flag, 6'h00};
				IESS_STAT_OFF:  rdata_nxt[IESS_EV_N-1:0] = stat_r;
				IESS_IEN_OFF:   rdata_nxt[IESS_EV_N-1:0] = ien_r;
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tmask_r <= IESS_RST8;
			ctrl_r  <= IESS_RST8;
			gmask_r <= IESS_RST8;
			ien_r   <= '0;
			stat_r  <= '0;
			slp_r   <= IESS_AWAKE;
			rdata_r <= 32'h0000_0000;
		end else begin
			tmask_r <= tmask_nxt;
			ctrl_r  <= ctrl_nxt;
			gmask_r <= gmask_nxt;
			ien_r   <= ien_nxt;
			stat_r  <= stat_nxt;
			slp_r   <= slp_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign prdata      = rdata_r;
	assign sleep_state = slp_r;
	assign irq         = |(stat_r & ien_r);

	sequence s_arm_exec;
		ctrl_r[IESS_SLEEP_ARM_BIT] && sleep_exec && slp_r == IESS_AWAKE;
	endsequence

	chk_t1ovf_vector: assert property (@(posedge pclk) disable iff (!presetn)
		(req == 7'b0100000) |-> (irq_req.valid && irq_req.vector == 12'h006))
		else $error("timer1 overflow vector wrong");
	chk_cmpa_vector: assert property (@(posedge pclk) disable iff (!presetn)
		(global_irq_en && tmask_r[6] && timer_flags.cmp_a_flag && req[2:0] == 3'b000)
		|-> irq_req.vector == 12'h004)
		else $error("compare A vector wrong");
	chk_cmpb_vector: assert property (@(posedge pclk) disable iff (!presetn)
		(req == 7'b0010000) |-> irq_req.vector == 12'h005)
		else $error("compare B vector wrong");
	chk_capture_vector: assert property (@(posedge pclk) disable iff (!presetn)
		(global_irq_en && tmask_r[3] && timer_flags.capture_flag && req[1:0] == 2'b00)
		|-> irq_req.vector == 12'h003)
		else $error("capture vector wrong");
	chk_t0ovf_vector: assert property (@(posedge pclk) disable iff (!presetn)
		(req == 7'b1000000) |-> irq_req.vector == 12'h007)
		else $error("timer0 overflow vector wrong");
	chk_mask_reserved: assert property (@(posedge pclk) disable iff (!presetn)
		(tmask_r & 8'h15) == 8'h00)
		else $error("reserved mask bit set");
	chk_sleep_needs_arm: assert property (@(posedge pclk) disable iff (!presetn)
		(slp_r == IESS_AWAKE && !(sleep_exec && ctrl_r[5])) |=> slp_r == IESS_AWAKE)
		else $error("slept without arm");
	chk_sleep_kind: assert property (@(posedge pclk) disable iff (!presetn)
		s_arm_exec |=> slp_r == ($past(ctrl_r[IESS_SLEEP_SEL_BIT]) ? IESS_PDOWN : IESS_IDLE))
		else $error("sleep kind wrong");
	chk_pdown_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(slp_r == IESS_PDOWN && grant[1:0] == 2'b00) |=> slp_r == IESS_PDOWN)
		else $error("power-down left without external request");
	chk_global_gate: assert property (@(posedge pclk) disable iff (!presetn)
		!global_irq_en |-> !irq_req.valid)
		else $error("request without global flag");
	chk_lowest_first: assert property (@(posedge pclk) disable iff (!presetn)
		(req[0]) |-> irq_req.vector == 12'h001)
		else $error("priority wrong");
endmodule

// [logic/iess_pkg.sv]
// Package: register map, field positions, vectors, types for the irq/sense/sleep block
package iess_pkg;
	// Register byte offsets (chosen layout, one word each)
	localparam logic [7:0] IESS_TMASK_OFF  = 8'h00;
	localparam logic [7:0] IESS_TFLAG_OFF  = 8'h04;
	localparam logic [7:0] IESS_CTRL_OFF   = 8'h08;
	localparam logic [7:0] IESS_GMASK_OFF  = 8'h0C;
	localparam logic [7:0] IESS_GFLAG_OFF  = 8'h10;
	localparam logic [7:0] IESS_STAT_OFF   = 8'h14;
	localparam logic [7:0] IESS_IEN_OFF    = 8'h18;
	localparam logic [7:0] IESS_ICLR_OFF   = 8'h1C;
	// Timer mask / flag bit positions
	localparam int IESS_T1OVF_BIT  = 7;
	localparam int IESS_CMPA_BIT   = 6;
	localparam int IESS_CMPB_BIT   = 5;
	localparam int IESS_CAP_BIT    = 3;
	localparam int IESS_T0OVF_BIT  = 1;
	localparam logic [7:0] IESS_TMASK_WMASK = 8'hEA;
	// Control register fields
	localparam int IESS_SLEEP_ARM_BIT = 5;
	localparam int IESS_SLEEP_SEL_BIT = 4;
	localparam int IESS_EXT1_SNS_LO   = 2;
	localparam int IESS_EXT0_SNS_LO   = 0;
	// General mask / flag bits
	localparam int IESS_EXT1_BIT = 7;
	localparam int IESS_EXT0_BIT = 6;
	localparam logic [7:0] IESS_GMASK_WMASK = 8'hC0;
	localparam logic [7:0] IESS_RST8 = 8'h00;
	// Vector addresses
	localparam logic [11:0] IESS_VEC_EXT0  = 12'h001;
	localparam logic [11:0] IESS_VEC_EXT1  = 12'h002;
	localparam logic [11:0] IESS_VEC_CAP   = 12'h003;
	localparam logic [11:0] IESS_VEC_CMPA  = 12'h004;
	localparam logic [11:0] IESS_VEC_CMPB  = 12'h005;
	localparam logic [11:0] IESS_VEC_T1OVF = 12'h006;
	localparam logic [11:0] IESS_VEC_T0OVF = 12'h007;
	localparam logic [11:0] IESS_VEC_NONE  = 12'h000;
	// Event status bits (sticky)
	localparam int IESS_EV_SLEEP = 0;
	localparam int IESS_EV_WAKE  = 1;
	localparam int IESS_EV_ACK   = 2;
	localparam int IESS_EV_N     = 3;

	typedef enum logic [1:0] {
		IESS_SNS_LOW  = 2'b00,
		IESS_SNS_RSV  = 2'b01,
		IESS_SNS_FALL = 2'b10,
		IESS_SNS_RISE = 2'b11
	} iess_sense_t;

	typedef enum logic [1:0] {
		IESS_AWAKE = 2'b00,
		IESS_IDLE  = 2'b01,
		IESS_PDOWN = 2'b10
	} iess_slp_t;

	// Timer flag inputs from the timer logic
	typedef struct packed {
		logic t1_ovf_flag;
		logic cmp_a_flag;
		logic cmp_b_flag;
		logic capture_flag;
		logic t0_ovf_flag;
	} iess_tflags_t;

	// Vectored request towards the core
	typedef struct packed {
		logic        valid;
		logic [11:0] vector;
	} iess_req_t;
endpackage

// [logic/iess_sense.sv]
// One external interrupt input: synchroniser, sense decode and flag
`timescale 1ns/100ps
module iess_sense
	import iess_pkg::*;
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Pin and control
	input  wire logic        pin,
	input  wire iess_pkg::iess_sense_t sense,
	input  wire logic        clr,
	// Result
	output logic             flag,
	output logic             level_req
);
	import iess_pkg::*;

	logic meta_r, sync_r, prev_r, flag_r;
	logic flag_nxt, fall, rise, edge_hit;

	always_comb begin
		fall      = prev_r & ~sync_r;
		rise      = ~prev_r & sync_r;
		edge_hit  = (sense == IESS_SNS_FALL) ? fall : (sense == IESS_SNS_RISE) ? rise : 1'b0;
		// Event wins over a same-cycle clear; level mode keeps it clear
		flag_nxt  = (edge_hit | (flag_r & ~clr)) & (sense != IESS_SNS_LOW);
		level_req = (sense == IESS_SNS_LOW) & ~sync_r;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r <= 1'b1;
			sync_r <= 1'b1;
			prev_r <= 1'b1;
			flag_r <= 1'b0;
		end else begin
			meta_r <= pin;
			sync_r <= meta_r;
			prev_r <= sync_r;
			flag_r <= flag_nxt;
		end
	end

	assign flag = flag_r;

	chk_level_follows_pin: assert property (@(posedge pclk) disable iff (!presetn)
		(sense == IESS_SNS_LOW && !sync_r) |-> level_req)
		else $error("level request missing while pin low");
	chk_fall_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
		(sense == IESS_SNS_FALL && $stable(sense) && fall) |=> flag_r)
		else $error("falling edge did not set flag");
	chk_level_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
		(sense == IESS_SNS_LOW) |=> !flag_r)
		else $error("flag set while level sensing");
endmodule

// [logic/iess_prio.sv]
// Fixed priority encoder: lowest vector wins
`timescale 1ns/100ps
module iess_prio
	import iess_pkg::*;
(
	// Requests, bit 0 is vector 1
	input  wire logic [6:0] req,
	// Winner
	output iess_pkg::iess_req_t win,
	output logic [6:0]      grant
);
	import iess_pkg::*;

	always_comb begin
		win   = '{valid: 1'b0, vector: IESS_VEC_NONE};
		grant = 7'h00;
		for (int i = 6; i >= 0; i--) begin
			if (req[i]) begin
				win   = '{valid: 1'b1, vector: 12'(i + 1)};
				grant = 7'(1 << i);
			end
		end
	end
endmodule

// [verif/iess_core_model.sv]
// Core-side model: acknowledges the winning vector when allowed
`timescale 1ns/100ps
module iess_core_model
	import iess_pkg::*;
(
	// Clock and reset
	input  wire logic      pclk,
	input  wire logic      presetn,
	// Control and request
	input  wire logic      ack_on,
	input  wire iess_req_t irq_req,
	// Acknowledge
	output logic           irq_ack,
	output logic [11:0]    irq_ack_vector
);
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_ack        <= 1'h0;
			irq_ack_vector <= 12'h000;
		end else begin
			// Gap after each ack so a cleared flag is not served twice
			irq_ack <= ack_on && irq_req.valid && !irq_ack;
			if (irq_req.valid && !irq_ack)
				irq_ack_vector <= irq_req.vector;
		end
	end
endmodule

// [verif/iess_top_tb_top.sv]
// Testbench for the interrupt enable, sense and sleep block
`timescale 1ns/100ps
module iess_top_tb_top;
	import iess_pkg::*;
	logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, slv;
	logic         global_irq_en, sleep_exec, irq_ack, ack_on, pin0, pin1;
	logic [7:0]   paddr;
	logic [31:0]  pwdata, prdata, rd;
	logic [11:0]  ack_vec;
	logic [3:0]   strb;
	iess_req_t    irq_req;
	iess_slp_t    sleep_state;
	iess_tflags_t tflags;
	int           err_total, checks_done;
	logic [11:0]  vt [5] = '{IESS_VEC_T1OVF, IESS_VEC_CMPA, IESS_VEC_CMPB, IESS_VEC_CAP,
		IESS_VEC_T0OVF};

	iess_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .global_irq_en(global_irq_en),
		.sleep_exec(sleep_exec), .irq_ack(irq_ack), .irq_ack_vector(ack_vec),
		.irq_req(irq_req), .sleep_state(sleep_state), .timer_flags(tflags),
		.ext_irq_pin_0(pin0), .ext_irq_pin_1(pin1), .irq(irq));
	iess_core_model i_core (.pclk(pclk), .presetn(presetn), .ack_on(ack_on),
		.irq_req(irq_req), .irq_ack(irq_ack), .irq_ack_vector(ack_vec));

	always #5 pclk = ~pclk;

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel   <= 1'h1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd = prdata;
		slv = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'h0, a, 32'h0);
		cmp(rd, exp);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic rq(input logic [12:0] exp);
		@(negedge pclk);
		cmp({19'h0, irq_req}, {19'h0, exp});
		// Hand back on a rising edge so stimulus never changes on the falling one
		@(posedge pclk);
	endtask
	task automatic slp(input iess_slp_t exp);
		@(posedge pclk);
		sleep_exec <= 1'h1;
		@(posedge pclk);
		sleep_exec <= 1'h0;
		@(negedge pclk);
		cmp({30'h0, sleep_state}, {30'h0, exp});
		@(posedge pclk);
	endtask
	task automatic complete_run();
		$display("checks=%0d mismatches=%0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge pclk);
		err_total++;
		complete_run();
	end

	initial begin
		pclk = 1'h0;
		presetn = 1'h0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{global_irq_en, sleep_exec, ack_on} = '0;
		{pin0, pin1} = 2'h3;
		strb = 4'hF;
		tflags = '0;
		err_total = 0;
		checks_done = 0;
		cyc(10);
		presetn <= 1'h1;
		rdc(IESS_CTRL_OFF, 32'h0);
		apb(1'h1, IESS_TMASK_OFF, 32'hFF);
		rdc(IESS_TMASK_OFF, 32'hEA);
		$display("test registers done");
		global_irq_en <= 1'h1;
		for (int i = 0; i < 5; i++) begin
			tflags <= iess_tflags_t'(5'h10 >> i);
			rq({1'h1, vt[i]});
		end
		tflags <= 5'h1F;
		rq({1'h1, IESS_VEC_CAP});
		rdc(IESS_TFLAG_OFF, 32'hEA);
		global_irq_en <= 1'h0;
		rq(13'h0);
		global_irq_en <= 1'h1;
		apb(1'h1, IESS_TMASK_OFF, 32'h0);
		tflags <= 5'h01;
		rq(13'h0);
		apb(1'h1, IESS_TMASK_OFF, 32'h02);
		rq({1'h1, IESS_VEC_T0OVF});
		// Byte lane 0 off: the write must be ignored
		strb <= 4'h0;
		apb(1'h1, IESS_TMASK_OFF, 32'hFF);
		strb <= 4'hF;
		rdc(IESS_TMASK_OFF, 32'h02);
		tflags <= 5'h00;
		$display("test timer vectors done");
		apb(1'h1, IESS_GMASK_OFF, 32'h40);
		apb(1'h1, IESS_CTRL_OFF, 32'h02);
		pin0 <= 1'h0;
		cyc(5);
		rq({1'h1, IESS_VEC_EXT0});
		apb(1'h1, IESS_GFLAG_OFF, 32'hC0);
		rq(13'h0);
		apb(1'h1, IESS_CTRL_OFF, 32'h03);
		pin0 <= 1'h1;
		cyc(5);
		rq({1'h1, IESS_VEC_EXT0});
		apb(1'h1, IESS_GFLAG_OFF, 32'hC0);
		apb(1'h1, IESS_CTRL_OFF, 32'h01);
		pin0 <= 1'h0;
		cyc(5);
		pin0 <= 1'h1;
		cyc(5);
		rq(13'h0);
		apb(1'h1, IESS_CTRL_OFF, 32'h00);
		pin0 <= 1'h0;
		cyc(5);
		rq({1'h1, IESS_VEC_EXT0});
		cyc(20);
		rq({1'h1, IESS_VEC_EXT0});
		rdc(IESS_GFLAG_OFF, 32'h0);
		pin0 <= 1'h1;
		cyc(5);
		rq(13'h0);
		apb(1'h1, IESS_CTRL_OFF, 32'h08);
		pin1 <= 1'h0;
		cyc(5);
		rq(13'h0);
		rdc(IESS_GFLAG_OFF, 32'h80);
		apb(1'h1, IESS_GMASK_OFF, 32'hC0);
		rq({1'h1, IESS_VEC_EXT1});
		ack_on <= 1'h1;
		cyc(3);
		rq(13'h0);
		cmp({20'h0, ack_vec}, {20'h0, IESS_VEC_EXT1});
		ack_on <= 1'h0;
		apb(1'h1, IESS_CTRL_OFF, 32'h0C);
		pin1 <= 1'h1;
		cyc(5);
		rq({1'h1, IESS_VEC_EXT1});
		apb(1'h1, IESS_GFLAG_OFF, 32'hC0);
		$display("test external sense done");
		apb(1'h1, IESS_CTRL_OFF, 32'h10);
		slp(IESS_AWAKE);
		apb(1'h1, IESS_CTRL_OFF, 32'h20);
		slp(IESS_IDLE);
		tflags <= 5'h01;
		cyc(3);
		cmp({30'h0, sleep_state}, {30'h0, IESS_AWAKE});
		tflags <= 5'h00;
		apb(1'h1, IESS_CTRL_OFF, 32'h30);
		slp(IESS_PDOWN);
		// A timer request must not end power-down, an external one must
		tflags <= 5'h01;
		cyc(3);
		cmp({30'h0, sleep_state}, {30'h0, IESS_PDOWN});
		pin0 <= 1'h0;
		cyc(5);
		cmp({30'h0, sleep_state}, {30'h0, IESS_AWAKE});
		pin0 <= 1'h1;
		tflags <= 5'h00;
		rdc(IESS_STAT_OFF, 32'h07);
		cmp({31'h0, irq}, 32'h0);
		apb(1'h1, IESS_IEN_OFF, 32'h01);
		cyc(1);
		cmp({31'h0, irq}, 32'h1);
		rdc(IESS_IEN_OFF, 32'h01);
		apb(1'h1, IESS_ICLR_OFF, 32'h07);
		cyc(1);
		cmp({31'h0, irq}, 32'h0);
		rdc(IESS_STAT_OFF, 32'h0);
		rdc(8'h20, 32'h0);
		cmp({31'h0, slv}, 32'h1);
		slp(IESS_PDOWN);
		// Mid-run reset must return sleep to awake and clear irq and masks
		presetn <= 1'h0;
		cyc(2);
		cmp({30'h0, sleep_state}, {30'h0, IESS_AWAKE});
		cmp({31'h0, irq}, 32'h0);
		presetn <= 1'h1;
		rdc(IESS_TMASK_OFF, 32'h0);
		rdc(IESS_GMASK_OFF, 32'h0);
		$display("test sleep and status done");
		complete_run();
	end
endmodule
